// [src/bcx_pkg.sv]
// Package for the break-cycle exit sequencer: states, request bundle and register map.
package bcx_pkg;

  // Address and opcode widths of the processor.
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned OP_W   = 3;

  // Major states, Gray coded along fetch, transfer, tally, execute.
  typedef enum logic [1:0] {
    BCX_ST_FETCH = 2'h0,
    BCX_ST_XFER  = 2'h1,
    BCX_ST_TALLY = 2'h3,
    BCX_ST_EXEC  = 2'h2
  } bcx_state_t;

  // Address path selections for the address register.
  typedef enum logic [1:0] {
    BCX_SEL_PTR  = 2'h0,
    BCX_SEL_DMA  = 2'h1,
    BCX_SEL_ZERO = 2'h2
  } bcx_sel_t;

  // Requests presented by the peripheral side.
  typedef struct packed {
    logic              dma;      // Data transfer request pending.
    logic              single;   // Transfer is the one-cycle type.
    logic              prog_int; // Program interrupt request pending.
    logic [ADDR_W-1:0] addr;     // Target location of the transfer.
  } bcx_req_t;

  // Forced subroutine-call opcode; default value is arbitrary.
  localparam logic [OP_W-1:0] SUB_CALL_OP = 3'h4;

  // Register byte offsets.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ADDR   = 4'h8;

  // Field positions and reset values.
  localparam int unsigned CTRL_INT_EN  = 0;
  localparam int unsigned STAT_SUSPEND = 4;
  localparam int unsigned ADDR_OP_LSB  = 16;
  localparam logic        CTRL_INT_EN_RST = 1'b0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [src/bcx_addr_reg.sv]
// Memory address register with its input selector and carry-insert incrementer.
`timescale 1ns/1ns
`default_nettype none
module bcx_addr_reg
  import bcx_pkg::*;
(
  input  wire logic              i_clk,     // System clock.
  input  wire logic              i_reset,   // Synchronous reset, high.
  input  wire logic              i_load,    // Load strobe.
  input  wire bcx_sel_t          i_sel,     // Source selection.
  input  wire logic              i_carry,   // Carry insert on the pointer path.
  input  wire logic [ADDR_W-1:0] i_ptr,     // Instruction pointer.
  input  wire logic [ADDR_W-1:0] i_dma,     // Transfer location.
  output logic      [ADDR_W-1:0] o_addr     // Registered address.
);

  // Pointer plus the inserted carry, wrapping at the top of memory.
  function automatic logic [ADDR_W-1:0] add_carry(input logic [ADDR_W-1:0] v, input logic c);
    add_carry = ADDR_W'(v + {{(ADDR_W-1){1'b0}}, c});
  endfunction

  // The register only changes on its strobe, so it holds across whole cycles.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_addr <= ADDR_RST;
    end else if (i_load) begin
      case (i_sel)
        BCX_SEL_PTR:  o_addr <= add_carry(i_ptr, i_carry);
        BCX_SEL_DMA:  o_addr <= i_dma;
        BCX_SEL_ZERO: o_addr <= ADDR_RST;
        default:      o_addr <= o_addr;
      endcase
    end
  end

endmodule
`default_nettype wire

// [src/bcx_sequencer.sv]
// Break-cycle exit sequencer: next major state selection with AXI4-Lite control.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - During the final transfer cycle all instruction execution stays suspended.
// - Returning to fetch enables the fetch-state set during slot four level.
// - On fetch return, load address with pointer, or pointer plus carry if skip.
// - Pending transfer location is gated during slot four and loaded at pulse.
// - One-cycle transfer request sets the transfer state at slot four pulse.
// - Three-cycle transfer request sets the tally phase state at slot four pulse.
// - Accepted program interrupt loads the address register with zero.
// - Accepted program interrupt forces the call opcode and enters execute.
module bcx_sequencer
  import bcx_pkg::*;
(
  input  wire logic              i_clk,              // 20 MHz system clock.
  input  wire logic              i_reset,            // Synchronous reset, high.
  input  wire logic              i_slot4_level,      // Time state four level.
  input  wire logic              i_slot4_pulse,      // Time pulse four, one cycle.
  input  wire bcx_pkg::bcx_req_t i_req,              // Peripheral requests.
  input  wire logic [ADDR_W-1:0] i_instr_pointer,    // Instruction pointer.
  input  wire logic              i_skip,             // Skip condition.
  input  wire bcx_pkg::bcx_state_t i_ext_next,       // Next state outside break.
  input  wire logic [3:0]        s_axi_awaddr,       // Write address.
  input  wire logic              s_axi_awvalid,      // Write address valid.
  output logic                   s_axi_awready,      // Write address ready.
  input  wire logic [31:0]       s_axi_wdata,        // Write data.
  input  wire logic [3:0]        s_axi_wstrb,        // Write strobes.
  input  wire logic              s_axi_wvalid,       // Write data valid.
  output logic                   s_axi_wready,       // Write data ready.
  output logic [1:0]             s_axi_bresp,        // Write response.
  output logic                   s_axi_bvalid,       // Write response valid.
  input  wire logic              s_axi_bready,       // Write response ready.
  input  wire logic [3:0]        s_axi_araddr,       // Read address.
  input  wire logic              s_axi_arvalid,      // Read address valid.
  output logic                   s_axi_arready,      // Read address ready.
  output logic [31:0]            s_axi_rdata,        // Read data.
  output logic [1:0]             s_axi_rresp,        // Read response.
  output logic                   s_axi_rvalid,       // Read data valid.
  input  wire logic              s_axi_rready,       // Read data ready.
  output logic [ADDR_W-1:0]      o_mem_addr_reg,     // Memory address register.
  output logic [OP_W-1:0]        o_opcode_latch,     // Opcode latch.
  output logic                   o_fetch_state,      // Instruction-read flag.
  output logic                   o_xfer_state,       // Transfer-cycle flag.
  output logic                   o_tally_phase_state,// Tally-phase flag.
  output logic                   o_exec_state,       // Execute flag.
  output logic                   o_instr_suspend,    // Instructions held off.
  output logic                   o_fetch_set_en,     // Fetch-state set enable.
  output logic                   o_dma_addr_gate,    // Transfer location gated.
  output logic                   o_address_reg_strobe// Address register loaded.
);

  bcx_state_t     state_q;
  bcx_state_t     state_d;
  bcx_sel_t       sel;
  logic           int_en_q;
  logic           take;
  logic           int_go;
  logic           fetch_go;

  // Decision taken at the pulse that ends the final break cycle.
  assign take     = (state_q == BCX_ST_XFER) && i_slot4_level && i_slot4_pulse;
  assign int_go   = !i_req.dma && i_req.prog_int && int_en_q;
  assign fetch_go = !i_req.dma && !int_go;

  // Transfers win over interrupts; a disabled interrupt falls back to fetch.
  always_comb begin
    state_d = i_ext_next;
    sel     = BCX_SEL_PTR;
    if (state_q == BCX_ST_XFER) begin
      if (i_req.dma) begin
        sel     = BCX_SEL_DMA;
        state_d = i_req.single ? BCX_ST_XFER : BCX_ST_TALLY;
      end else if (int_go) begin
        sel     = BCX_SEL_ZERO;
        state_d = BCX_ST_EXEC;
      end else begin
        state_d = BCX_ST_FETCH;
      end
    end
  end

  // Major state advances only at the slot four pulse.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= BCX_ST_FETCH;
    end else if (i_slot4_pulse) begin
      state_q <= state_d;
    end
  end

  // One-hot flags decoded from the next state so that they are flops too.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_fetch_state       <= 1'b1;
      o_xfer_state        <= 1'b0;
      o_tally_phase_state <= 1'b0;
      o_exec_state        <= 1'b0;
      o_instr_suspend     <= 1'b0;
    end else if (i_slot4_pulse) begin
      o_fetch_state       <= (state_d == BCX_ST_FETCH);
      o_xfer_state        <= (state_d == BCX_ST_XFER);
      o_tally_phase_state <= (state_d == BCX_ST_TALLY);
      o_exec_state        <= (state_d == BCX_ST_EXEC);
      o_instr_suspend     <= (state_d == BCX_ST_XFER);
    end
  end

  // Level enables during slot four; they lag the inputs by one clock.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_fetch_set_en  <= 1'b0;
      o_dma_addr_gate <= 1'b0;
    end else begin
      o_fetch_set_en  <= (state_q == BCX_ST_XFER) && i_slot4_level && fetch_go;
      o_dma_addr_gate <= (state_q == BCX_ST_XFER) && i_slot4_level && i_req.dma;
    end
  end

  // Strobe marks the cycle after the address register was loaded.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_address_reg_strobe <= 1'b0;
    end else begin
      o_address_reg_strobe <= take;
    end
  end

  // Opcode latch is held while suspended and only forced on an interrupt.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_opcode_latch <= '0;
    end else if (take && int_go) begin
      o_opcode_latch <= SUB_CALL_OP;
    end
  end

  // Address register with the pointer, transfer and zero paths.
  bcx_addr_reg u_addr (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_load  (take),
    .i_sel   (sel),
    .i_carry (i_skip),
    .i_ptr   (i_instr_pointer),
    .i_dma   (i_req.addr),
    .o_addr  (o_mem_addr_reg)
  );

  // AXI4-Lite write side: address and data are caught in either order.
  logic       aw_have_q;
  logic       w_have_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_fire;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // Ready is offered only while the matching holding slot is empty.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Control register and write response.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      int_en_q     <= CTRL_INT_EN_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      if (aw_addr_q == REG_CTRL && w_strb_q[0]) begin
        int_en_q <= w_data_q[CTRL_INT_EN];
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side: one cycle from address acceptance to data.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
      case (s_axi_araddr)
        REG_CTRL:   s_axi_rdata[CTRL_INT_EN] <= int_en_q;
        REG_STATUS: s_axi_rdata[STAT_SUSPEND:0] <= {o_instr_suspend, o_exec_state,
                      o_tally_phase_state, o_xfer_state, o_fetch_state};
        REG_ADDR: begin
          s_axi_rdata[ADDR_W-1:0]          <= o_mem_addr_reg;
          s_axi_rdata[ADDR_OP_LSB +: OP_W] <= o_opcode_latch;
        end
        default:    s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // Checks on the sequencer's behaviour.
  AST_HOLD_OP: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_instr_suspend && !$past(take)) |-> $stable(o_opcode_latch))
    else $error("Opcode latch changed while instructions are suspended.");
  AST_FETCH_EN: assert property (@(posedge i_clk) disable iff (i_reset)
    ((state_q == BCX_ST_XFER) && i_slot4_level && fetch_go) |=> o_fetch_set_en)
    else $error("Fetch set enable missing on return to fetch.");
  AST_PTR_LOAD: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && fetch_go) |=> (o_mem_addr_reg ==
      ADDR_W'($past(i_instr_pointer) + {{(ADDR_W-1){1'b0}}, $past(i_skip)})) && o_fetch_state)
    else $error("Pointer return address wrong.");
  AST_DMA_LOAD: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && i_req.dma) |=> (o_mem_addr_reg == $past(i_req.addr)) && o_address_reg_strobe)
    else $error("Transfer location not loaded.");
  AST_SINGLE: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && i_req.dma && i_req.single) |=> o_xfer_state && o_instr_suspend)
    else $error("One-cycle transfer did not enter transfer state.");
  AST_TRIPLE: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && i_req.dma && !i_req.single) |=> o_tally_phase_state && !o_instr_suspend)
    else $error("Three-cycle transfer did not enter tally phase.");
  AST_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && int_go) |=> (o_mem_addr_reg == ADDR_RST))
    else $error("Interrupt did not clear the address register.");
  AST_CALL: assert property (@(posedge i_clk) disable iff (i_reset)
    (take && int_go) |=> (o_opcode_latch == SUB_CALL_OP) && o_exec_state)
    else $error("Interrupt did not force the call opcode.");
  AST_ONEHOT: assert property (@(posedge i_clk) disable iff (i_reset)
    $past(i_slot4_pulse) |-> $onehot({o_fetch_state, o_xfer_state,
      o_tally_phase_state, o_exec_state}))
    else $error("Major state flags not one-hot.");

endmodule
`default_nettype wire

// [verif/bcx_periph_model.sv]
// Peripheral request model: presents cycle-steal requests and their target location.
`timescale 1ns/1ns
`default_nettype none
module bcx_periph_model
  import bcx_pkg::*;
(
  input  wire logic              i_clk,    // System clock.
  input  wire logic              i_post,   // Request held while high.
  input  wire logic              i_dma,    // Data transfer wanted.
  input  wire logic              i_single, // One-cycle transfer type.
  input  wire logic              i_int,    // Program interrupt wanted.
  input  wire logic [ADDR_W-1:0] i_addr,   // Target location.
  output var bcx_pkg::bcx_req_t  o_req     // Request bundle to the sequencer.
);
  initial o_req = '0;
  // Requests change just after an edge; an idle address churns so a stale one never matches.
  always @(posedge i_clk) begin
    if (i_post) begin
      o_req <= '{dma: i_dma, single: i_single, prog_int: i_int, addr: i_addr};
    end else begin
      o_req.dma      <= 1'h0;
      o_req.single   <= 1'h0;
      o_req.prog_int <= 1'h0;
      o_req.addr     <= ~o_req.addr;
    end
  end
endmodule
`default_nettype wire

// [verif/bcx_sequencer_tb.sv]
// Self-checking testbench for the break-cycle exit sequencer.
`timescale 1ns/1ns
`default_nettype none
module bcx_sequencer_tb;
  import bcx_pkg::*;
  localparam logic   LO = 1'h0;
  localparam logic   HI = 1'h1;
  logic              i_clk = LO;
  logic              i_reset = HI;
  logic              slot4_level = LO, slot4_pulse = LO, skip = LO;
  logic [ADDR_W-1:0] ptr = '0, p_addr = '0;
  bcx_state_t        ext_next = BCX_ST_FETCH;
  logic              post = LO, p_dma = LO, p_single = LO, p_int = LO;
  logic [3:0]        awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = 4'hF;
  logic              awvalid = LO, wvalid = LO, bready = LO, arvalid = LO, rready = LO;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [ADDR_W-1:0] mem_addr;
  logic [OP_W-1:0]   opcode;
  logic              st_f, st_x, st_t, st_e, suspend, fetch_en, dma_gate, strobe;
  bcx_req_t          req;
  int                n_errors = 0;
  int                total_checks = 0;

  // Free-running 20 MHz clock.
  always begin
    #25;
    i_clk = ~i_clk;
  end

  // Byte-lane strobes are driven so a write without lane zero can be shown to be ignored.
  bcx_sequencer i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_slot4_level(slot4_level),
    .i_slot4_pulse(slot4_pulse), .i_req(req), .i_instr_pointer(ptr), .i_skip(skip),
    .i_ext_next(ext_next), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .o_mem_addr_reg(mem_addr), .o_opcode_latch(opcode), .o_fetch_state(st_f),
    .o_xfer_state(st_x), .o_tally_phase_state(st_t), .o_exec_state(st_e),
    .o_instr_suspend(suspend), .o_fetch_set_en(fetch_en), .o_dma_addr_gate(dma_gate),
    .o_address_reg_strobe(strobe));

  bcx_periph_model i_periph (.i_clk(i_clk), .i_post(post), .i_dma(p_dma),
    .i_single(p_single), .i_int(p_int), .i_addr(p_addr), .o_req(req));

  // Prints the verdict and stops the run.
  task automatic end_sim;
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Four-state compare so that an unknown never passes.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One register access; handshakes are judged on settled values before each edge.
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] eresp, input logic [31:0] edata);
    logic        hs_a, hs_w, done;
    logic [1:0]  resp;
    logic [31:0] data;
    int          n;
    done = LO;
    @(posedge i_clk);
    if (wr) begin
      awaddr  <= a;
      wdata   <= d;
      awvalid <= HI;
      wvalid  <= HI;
      bready  <= HI;
    end else begin
      araddr  <= a;
      arvalid <= HI;
      rready  <= HI;
    end
    for (n = 0; n < 40 && !done; n++) begin
      #1;
      hs_a = (awvalid && awready) || (arvalid && arready);
      hs_w = wvalid && wready;
      done = (bready && bvalid) || (rready && rvalid);
      resp = wr ? bresp : rresp;
      data = rdata;
      @(posedge i_clk);
      if (hs_a) begin
        awvalid <= LO;
        arvalid <= LO;
      end
      if (hs_w) begin
        wvalid <= LO;
      end
    end
    bready <= LO;
    rready <= LO;
    if (!done) begin
      n_errors++;
      $display("MISMATCH t=%0t bus answer never came", $time);
      end_sim();
    end else begin
      chk(resp, eresp);
      chk(wr ? edata : data, edata);
    end
  endtask

  // Enters the break state if needed, posts a request, then fires slot four.
  task automatic decide(input logic dma, input logic single, input logic intr,
      input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] p, input logic sk,
      input logic [ADDR_W-1:0] ea, input bcx_state_t es);
    @(posedge i_clk);
    post     <= HI;
    p_dma    <= dma;
    p_single <= single;
    p_int    <= intr;
    p_addr   <= a;
    ptr      <= p;
    skip     <= sk;
    if (st_x !== HI) begin
      slot4_level <= HI;
      slot4_pulse <= HI;
      ext_next    <= BCX_ST_XFER;
      @(posedge i_clk);
      slot4_level <= LO;
      slot4_pulse <= LO;
      ext_next    <= BCX_ST_FETCH;
    end
    #1;
    chk({st_x, suspend}, 32'h0000_0003);
    @(posedge i_clk);
    slot4_level <= HI;
    @(posedge i_clk);
    slot4_pulse <= HI;
    #1;
    chk({dma_gate, fetch_en}, {dma, es == BCX_ST_FETCH});
    @(posedge i_clk);
    slot4_level <= LO;
    slot4_pulse <= LO;
    post        <= LO;
    #1;
    chk(mem_addr, ea);
    chk({st_f, st_x, st_t, st_e, strobe}, {es == BCX_ST_FETCH, es == BCX_ST_XFER,
        es == BCX_ST_TALLY, es == BCX_ST_EXEC, HI});
    chk(suspend, es == BCX_ST_XFER);
    chk(opcode, es == BCX_ST_EXEC ? SUB_CALL_OP : {OP_W{1'b0}});
  endtask

  // Main sequence: reset, register map, then every exit path of the break cycle.
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= LO;
    axi(LO, REG_CTRL, '0, RESP_OKAY, 32'h0000_0000);
    axi(LO, REG_STATUS, '0, RESP_OKAY, 32'h0000_0001);
    axi(LO, REG_ADDR, '0, RESP_OKAY, 32'h0000_0000);
    axi(LO, 4'hC, '0, RESP_SLVERR, 32'h0000_0000);
    axi(HI, REG_STATUS, 32'h0000_001F, RESP_SLVERR, '0);
    decide(LO, LO, LO, 12'h000, 12'h123, LO, 12'h123, BCX_ST_FETCH);
    decide(LO, LO, LO, 12'h000, 12'hFFF, HI, 12'h000, BCX_ST_FETCH);
    decide(LO, LO, HI, 12'h000, 12'h456, HI, 12'h457, BCX_ST_FETCH);
    wstrb <= 4'h0;
    axi(HI, REG_CTRL, 32'h0000_0001, RESP_OKAY, '0);
    axi(LO, REG_CTRL, '0, RESP_OKAY, 32'h0000_0000);
    wstrb <= 4'hF;
    axi(HI, REG_CTRL, 32'h0000_0001, RESP_OKAY, '0);
    axi(LO, REG_CTRL, '0, RESP_OKAY, 32'h0000_0001);
    decide(HI, HI, LO, 12'hA5C, 12'h111, LO, 12'hA5C, BCX_ST_XFER);
    decide(HI, HI, HI, 12'h001, 12'h111, HI, 12'h001, BCX_ST_XFER);
    decide(HI, LO, HI, 12'h7FF, 12'h222, LO, 12'h7FF, BCX_ST_TALLY);
    decide(LO, LO, HI, 12'h3C3, 12'h333, HI, 12'h000, BCX_ST_EXEC);
    axi(LO, REG_ADDR, '0, RESP_OKAY, {13'h0000, SUB_CALL_OP, 16'h0000});
    axi(LO, REG_STATUS, '0, RESP_OKAY, 32'h0000_0008);
    end_sim();
  end
endmodule
`default_nettype wire
